/* File: fpl_ext_src.sv */
`timescale 1ns/1ps
// External programming voltage source seen by the supply. It slews toward
// its target so a step lands over several cycles, like a filtered source.
module fpl_ext_src (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// Requested and driven level, mV
	input  wire logic signed [15:0] target,
	output logic signed [15:0]      ext_mv
);
	localparam logic signed [15:0] STEP = 16'sh0032;

	// level in mV
	// Slew limit, so the supply sees intermediate nonzero values
	always @(posedge clk) begin
		if (!reset_n)
			ext_mv <= #2 16'sh0000;
		else if (target > ext_mv + STEP)
			ext_mv <= #2 ext_mv + STEP;
		else if (target < ext_mv - STEP)
			ext_mv <= #2 ext_mv - STEP;
		else
			ext_mv <= #2 target;
	end
endmodule

/* File: fpl_front_panel.sv */
`timescale 1ns/1ps
module fpl_front_panel #(
	parameter int unsigned HOLD = fpl_pkg::HOLD_CYCLES
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               clk_en,
	// Keypad events, one-cycle pulses
	input  wire logic               key_up,
	input  wire logic               key_down,
	input  wire logic               key_enter,
	input  wire logic               key_escape,
	input  wire logic               key_ext_prog,
	input  wire logic               key_comp_if,
	input  wire logic               key_local,
	input  wire logic               key_digit_vld,
	input  wire logic [3:0]         key_digit,
	// Keypad levels for the hold timers
	input  wire logic               enter_level,
	input  wire logic               escape_level,
	// Operating requests from keypad
	input  wire logic               key_set_wr,
	input  wire logic signed [23:0] key_set_val,
	input  wire logic               key_zero,
	input  wire logic               key_heater_on,
	input  wire logic               key_heater_off,
	input  wire logic               key_param_wr,
	input  wire logic [3:0]         key_param_idx,
	input  wire logic [15:0]        key_param_val,
	input  wire logic [3:0]         param_rd_idx,
	// Computer side
	input  wire logic               remote_req,
	input  wire logic               host_code_wr,
	input  wire logic [11:0]        host_code,
	// External programming input, mV
	input  wire logic signed [15:0] ext_mv,
	// Outputs
	output logic signed [23:0]      setpoint_ff,
	output logic signed [23:0]      i_cmd_ff,
	output fpl_pkg::fpl_src_t       src_ff,
	output fpl_pkg::fpl_lock_t      lock_ff,
	output fpl_pkg::fpl_baud_t      baud_ff,
	output logic [4:0]              bus_addr_ff,
	output fpl_pkg::fpl_term_t      term_ff,
	output fpl_pkg::fpl_msg_t       msg_ff,
	output logic [3:0]              screen_ff,
	output logic [1:0]              sel_ff,
	output logic [1:0]              stars_ff,
	output logic [15:0]             version_ff,
	output logic                    remote_led_ff,
	output logic                    heater_on_ff,
	output logic                    restore_busy_ff,
	output logic [15:0]             param_rd_data
);
	import fpl_pkg::*;

	typedef enum logic [3:0] {ST_NORMAL, ST_SRC, ST_BAUD, ST_ADDR, ST_TERM,
		ST_LOCK, ST_CODE, ST_DEFQ, ST_RESTORE} fpl_state_t;

	fpl_state_t         state_ff;
	fpl_state_t         nxt_state;
	fpl_lock_t          pend_lock_ff;
	logic [4:0]         pend_ff;
	logic [11:0]        code_ff;
	logic [11:0]        entry_ff;
	logic [3:0]         rst_idx_ff;
	logic [1:0]         held;
	logic               keys_ok;
	logic               code_done;
	logic               code_match;
	logic               mem_we;
	logic [3:0]         mem_idx;
	logic [15:0]        mem_dat;
	logic signed [23:0] ext_ma;

	// May a change be made under this lock; oper marks operating params
	function automatic logic chg_ok(fpl_lock_t lk, logic oper);
		chg_ok = (lk == LK_NONE) || (lk == LK_LIMITS && oper);
	endfunction

	// Default word for each parameter index
	function automatic logic [15:0] def_val(logic [3:0] idx);
		unique case (idx)
			IDX_RAMP: def_val = DEF_RAMP;
			IDX_VLIM: def_val = DEF_VLIM;
			IDX_IMAX: def_val = DEF_IMAX;
			IDX_STEP: def_val = DEF_STEP;
			default:  def_val = DEF_QUENCH;
		endcase
	endfunction

	// hold detect
	// One timer per key; same structure, so a generate loop
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_hold
			fpl_hold_timer #(.HOLD(HOLD)) u_hold (
				.clk       (clk),
				.reset_n   (reset_n),
				.clk_en    (clk_en),
				.key_level (g == 0 ? enter_level : escape_level),
				.held_pulse(held[g])
			);
		end
	endgenerate

	assign keys_ok    = !remote_led_ff;
	assign code_done  = key_digit_vld && stars_ff == 2'd2;
	assign code_match = {entry_ff[7:0], key_digit} == code_ff;
	assign ext_ma     = 24'(ext_mv) * 24'(EXT_MA_PER_MV);

	// restore walks parameter words only, below calibration
	assign mem_we  = (state_ff == ST_RESTORE) ||
		(keys_ok && key_param_wr && state_ff == ST_NORMAL &&
		 key_param_idx < CAL_BASE &&
		 chg_ok(lock_ff, key_param_idx == IDX_RAMP ||
		                 key_param_idx == IDX_VLIM));
	assign mem_idx = (state_ff == ST_RESTORE) ? rst_idx_ff : key_param_idx;
	assign mem_dat = (state_ff == ST_RESTORE) ? def_val(rst_idx_ff)
	                                           : key_param_val;

	fpl_param_mem #(.W(16), .D(16)) u_mem (
		.clk    (clk),
		.clk_en (clk_en),
		.wr_en  (mem_we),
		.wr_idx (mem_idx),
		.wr_data(mem_dat),
		.rd_idx (param_rd_idx),
		.rd_data(param_rd_data)
	);

	// Screen sequencing
	always_comb begin
		nxt_state = state_ff;
		if (state_ff == ST_RESTORE) begin
			if (rst_idx_ff == NUM_PARAMS - 4'h1)
				nxt_state = ST_NORMAL;
		end else if (keys_ok) begin
			unique case (state_ff)
				ST_NORMAL: begin
					if (held[0])
						nxt_state = ST_LOCK;
					else if (held[1])
						nxt_state = ST_DEFQ;
					else if (key_ext_prog)
						nxt_state = ST_SRC;
					else if (key_comp_if)
						nxt_state = ST_BAUD;
				end
				ST_BAUD: begin
					if (key_escape)
						nxt_state = ST_NORMAL;
					else if (key_enter)
						nxt_state = ST_ADDR;
				end
				ST_ADDR: begin
					if (key_escape)
						nxt_state = ST_NORMAL;
					else if (key_enter)
						nxt_state = ST_TERM;
				end
				ST_LOCK: begin
					if (key_escape)
						nxt_state = ST_NORMAL;
					else if (key_enter)
						nxt_state = ST_CODE;
				end
				ST_CODE: begin
					if (key_escape || code_done)
						nxt_state = ST_NORMAL;
				end
				ST_DEFQ: begin
					if (key_escape)
						nxt_state = ST_NORMAL;
					else if (key_enter)
						nxt_state = (pend_ff[0] && lock_ff == LK_NONE)
							? ST_RESTORE : ST_NORMAL;
				end
				default: begin
					if (key_escape || key_enter)
						nxt_state = ST_NORMAL;
				end
			endcase
		end
	end

	// State, screen number and restore walk
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_ff        <= ST_NORMAL;
			rst_idx_ff      <= 4'h0;
			restore_busy_ff <= 1'b0;
		end else if (clk_en) begin
			state_ff        <= nxt_state;
			restore_busy_ff <= nxt_state == ST_RESTORE;
			rst_idx_ff      <= (state_ff == ST_RESTORE)
				? rst_idx_ff + 4'h1 : 4'h0;
		end
	end
	assign screen_ff = state_ff;

	// Pending selection, loaded from the live value on entry to a source, interface or lock screen, else zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pend_ff <= 5'h00;
		end else if (clk_en && keys_ok) begin
			if (nxt_state != state_ff) begin
				unique case (nxt_state)
					ST_SRC:  pend_ff <= {3'b000, src_ff};
					ST_BAUD: pend_ff <= {3'b000, baud_ff};
					ST_ADDR: pend_ff <= bus_addr_ff;
					ST_TERM: pend_ff <= {3'b000, term_ff};
					ST_LOCK: pend_ff <= {3'b000, lock_ff};
					default: pend_ff <= 5'h00;
				endcase
			end else if (state_ff == ST_ADDR) begin
				if (key_up && pend_ff < ADDR_MAX)
					pend_ff <= pend_ff + 5'h01;
				else if (key_down && pend_ff > ADDR_MIN)
					pend_ff <= pend_ff - 5'h01;
			end else if (key_up || key_down) begin
				if (state_ff == ST_SRC || state_ff == ST_LOCK)
					pend_ff <= (key_up)
						? ((pend_ff[1:0] == 2'd2) ? 5'h00 : pend_ff + 5'h01)
						: ((pend_ff[1:0] == 2'd0) ? 5'h02 : pend_ff - 5'h01);
				else
					pend_ff <= {3'b000, pend_ff[1:0] + (key_up ? 2'd1 : 2'd3)};
			end
		end
	end
	assign sel_ff = pend_ff[1:0];

	// Committed configuration
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			src_ff      <= SRC_INT;
			baud_ff     <= BD_9600;
			bus_addr_ff <= ADDR_DEFAULT;
			term_ff     <= TM_CRLF;
		end else if (clk_en) begin
			// restore returns the interface and source defaults
			if (state_ff == ST_RESTORE) begin
				src_ff      <= SRC_INT;
				baud_ff     <= BD_9600;
				bus_addr_ff <= ADDR_DEFAULT;
				term_ff     <= TM_CRLF;
			end else if (keys_ok && key_enter && lock_ff == LK_NONE) begin
				unique case (state_ff)
					ST_SRC: begin
						if (ext_mv == 16'sh0000 && setpoint_ff == 24'sh00_0000)
							src_ff <= fpl_src_t'(pend_ff[1:0]);
					end
					ST_BAUD: baud_ff <= fpl_baud_t'(pend_ff[1:0]);
					ST_ADDR: bus_addr_ff <= pend_ff;
					ST_TERM: term_ff <= fpl_term_t'(pend_ff[1:0]);
					default: ;
				endcase
			end
		end
	end

	// Lock mode, code and code entry
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			lock_ff      <= LK_NONE;
			pend_lock_ff <= LK_NONE;
			code_ff      <= CODE_DEFAULT;
			entry_ff     <= 12'h000;
			stars_ff     <= 2'd0;
		end else if (clk_en) begin
			// restore brings back the factory code
			if (state_ff == ST_RESTORE) begin
				code_ff <= CODE_DEFAULT;
				lock_ff <= LK_NONE;
			// code written only by the computer
			end else if (host_code_wr) begin
				code_ff <= host_code;
			end
			if (keys_ok && state_ff == ST_LOCK && key_enter)
				pend_lock_ff <= fpl_lock_t'(pend_ff[1:0]);
			if (state_ff != ST_CODE) begin
				stars_ff <= 2'd0;
				entry_ff <= 12'h000;
			end else if (keys_ok && key_digit_vld) begin
				stars_ff <= stars_ff + 2'd1;
				entry_ff <= {entry_ff[7:0], key_digit};
				if (code_done && code_match)
					lock_ff <= pend_lock_ff;
			end
		end
	end

	// Panel setpoint, heater and remote state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			setpoint_ff   <= 24'sh00_0000;
			heater_on_ff  <= 1'b0;
			remote_led_ff <= 1'b0;
		end else if (clk_en) begin
			if (key_local)
				remote_led_ff <= 1'b0;
			else if (remote_req)
				remote_led_ff <= 1'b1;
			if (state_ff == ST_RESTORE) begin
				setpoint_ff  <= 24'sh00_0000;
				heater_on_ff <= 1'b0;
			end else if (src_ff == SRC_EXT) begin
				setpoint_ff <= 24'sh00_0000;
			end else if (keys_ok && state_ff == ST_NORMAL &&
			             chg_ok(lock_ff, 1'b1)) begin
				if (key_zero)
					setpoint_ff <= 24'sh00_0000;
				else if (key_set_wr)
					setpoint_ff <= key_set_val;
			end
			if (keys_ok && state_ff == ST_NORMAL && chg_ok(lock_ff, 1'b1)) begin
				if (key_heater_on)
					heater_on_ff <= 1'b1;
				else if (key_heater_off)
					heater_on_ff <= 1'b0;
			end
		end
	end

	// Output command; external part deliberately unclamped
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			i_cmd_ff <= 24'sh00_0000;
		end else if (clk_en) begin
			// no maximum clamp on the external part
			unique case (src_ff)
				SRC_EXT: i_cmd_ff <= ext_ma;
				SRC_SUM: i_cmd_ff <= setpoint_ff + ext_ma;
				default: i_cmd_ff <= setpoint_ff;
			endcase
		end
	end

	// Display messages and version readout
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			msg_ff     <= MSG_NONE;
			version_ff <= 16'h0000;
		end else if (clk_en) begin
			// versions shown with the defaults prompt
			version_ff <= (nxt_state == ST_DEFQ)
				? {MAIN_VERSION, CONV_VERSION} : 16'h0000;
			if (keys_ok && key_enter && state_ff == ST_SRC &&
			    lock_ff == LK_NONE && ext_mv != 16'sh0000)
				msg_ff <= MSG_VOLT_NZ;
			else if (keys_ok && key_enter && state_ff == ST_SRC &&
			         lock_ff == LK_NONE && setpoint_ff != 24'sh00_0000)
				msg_ff <= MSG_SET_NZ;
			else if (keys_ok && key_enter && lock_ff != LK_NONE &&
			         (state_ff inside {ST_SRC, ST_BAUD, ST_ADDR, ST_TERM} ||
			          (state_ff == ST_DEFQ && pend_ff[0])))
				msg_ff <= MSG_LOCKED;
			else if (keys_ok && state_ff == ST_NORMAL &&
			         ((key_param_wr && !mem_we) ||
			          (!chg_ok(lock_ff, 1'b1) && (key_set_wr || key_zero ||
			           key_heater_on || key_heater_off))))
				msg_ff <= MSG_LOCKED;
			else if (keys_ok && state_ff == ST_CODE && code_done)
				msg_ff <= code_match ? MSG_ACCEPTED : MSG_INVALID;
			else if (keys_ok && (key_escape || key_ext_prog || key_comp_if))
				msg_ff <= MSG_NONE;
		end
	end

	// Checks
	property p_ext_zero;
		@(posedge clk) disable iff (!reset_n)
		src_ff == SRC_EXT && clk_en |=> setpoint_ff == 24'sh00_0000;
	endproperty
	a_ext_zero: assert property (p_ext_zero)
		else $error("setpoint not held at zero in external mode");

	property p_sum;
		@(posedge clk) disable iff (!reset_n)
		src_ff == SRC_SUM && clk_en
			|=> i_cmd_ff == $past(setpoint_ff) + $past(ext_ma);
	endproperty
	a_sum: assert property (p_sum)
		else $error("summed command wrong");

	property p_src_reject;
		@(posedge clk) disable iff (!reset_n)
		clk_en && keys_ok && state_ff == ST_SRC && key_enter &&
		lock_ff == LK_NONE && ext_mv != 16'sh0000
			|=> $stable(src_ff) && msg_ff == MSG_VOLT_NZ;
	endproperty
	a_src_reject: assert property (p_src_reject)
		else $error("source changed with external voltage present");

	property p_code_bad;
		@(posedge clk) disable iff (!reset_n)
		clk_en && keys_ok && state_ff == ST_CODE && code_done && !code_match
			|=> $stable(lock_ff) && msg_ff == MSG_INVALID
			    && state_ff == ST_NORMAL;
	endproperty
	a_code_bad: assert property (p_code_bad)
		else $error("lock mode changed on wrong code");

	property p_full_lock;
		@(posedge clk) disable iff (!reset_n)
		clk_en && keys_ok && lock_ff == LK_ALL && state_ff == ST_NORMAL &&
		key_set_wr |=> $stable(setpoint_ff) && msg_ff == MSG_LOCKED;
	endproperty
	a_full_lock: assert property (p_full_lock)
		else $error("full lock let setpoint change");

	property p_restore_refuse;
		@(posedge clk) disable iff (!reset_n)
		clk_en && keys_ok && state_ff == ST_DEFQ && key_enter &&
		lock_ff != LK_NONE |=> state_ff == ST_NORMAL ##1 !restore_busy_ff;
	endproperty
	a_restore_refuse: assert property (p_restore_refuse)
		else $error("restore started while locked");

	property p_restore_code;
		@(posedge clk) disable iff (!reset_n)
		$fell(restore_busy_ff) |-> code_ff == CODE_DEFAULT
			&& lock_ff == LK_NONE && src_ff == SRC_INT;
	endproperty
	a_restore_code: assert property (p_restore_code)
		else $error("restore left code or source changed");

	property p_reset_state;
		@(posedge clk)
		!reset_n |=> setpoint_ff == 24'sh00_0000 && !heater_on_ff
			&& !remote_led_ff;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("power-up state not safe");

	property p_remote;
		@(posedge clk) disable iff (!reset_n)
		clk_en && remote_led_ff && !key_local && state_ff == ST_NORMAL
			|=> state_ff == ST_NORMAL;
	endproperty
	a_remote: assert property (p_remote)
		else $error("keypad acted in remote");
endmodule

/* File: fpl_hold_timer.sv */
`timescale 1ns/1ps
// Pulses once when a key level has been held for HOLD cycles
module fpl_hold_timer #(
	parameter int unsigned HOLD = fpl_pkg::HOLD_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic clk_en,
	// Key level and hold event
	input  wire logic key_level,
	output logic      held_pulse
);
	import fpl_pkg::*;
	logic [31:0] cnt_ff;

	// Count while held; saturate so one long hold fires only once
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cnt_ff     <= 32'h0000_0000;
			held_pulse <= 1'b0;
		end else if (clk_en) begin
			held_pulse <= key_level && (cnt_ff == HOLD - 1);
			if (!key_level)
				cnt_ff <= 32'h0000_0000;
			else if (cnt_ff < HOLD)
				cnt_ff <= cnt_ff + 32'h0000_0001;
		end
	end
endmodule

/* File: fpl_param_mem.sv */
`timescale 1ns/1ps
// Nonvolatile parameter image; read data is registered
module fpl_param_mem #(
	parameter int W = 16,
	parameter int D = 16
) (
	// Clock
	input  wire logic                 clk,
	input  wire logic                 clk_en,
	// Write port
	input  wire logic                 wr_en,
	input  wire logic [$clog2(D)-1:0] wr_idx,
	input  wire logic [W-1:0]         wr_data,
	// Read port
	input  wire logic [$clog2(D)-1:0] rd_idx,
	output logic      [W-1:0]         rd_data
);
	import fpl_pkg::*;
	logic [W-1:0] mem [D];

	// No reset: contents survive like the real storage would
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (wr_en)
				mem[wr_idx] <= wr_data;
			rd_data <= mem[rd_idx];
		end
	end
endmodule

/* File: fpl_pkg.sv */
// Overview of operation
// - Source select offers internal, external, or internal plus external.
// - External mode holds panel setpoint at zero; 1 V external gives 10 A.
// - Sum mode drives the sum of panel setpoint and external value.
// - Maximum-current limits never clamp the external contribution.
// - Source change refused while external voltage or setpoint nonzero.
// - Confirm commits and advances; cancel discards and returns to normal.
// - Locked keypad allows viewing only; full lock blocks every change.
// - Limits lock still allows setpoint, ramp, voltage limit, output ops.
// - Lock code is three digits, default 123, written only by computer.
// - Restoring defaults also restores the factory lock code.
// - Restore-defaults request refused while keypad is locked.
// - Confirm held five seconds opens lock-mode selection screen.
// - New lock mode applies only on code match; mismatch reports invalid.
// - Locked change attempt refused with a keypad-locked message.
// - Baud selectable 9600, 19200, 38400, 57600; default 9600.
// - Bus address 1 through 30, default twelve, set from the panel.
// - Terminator CR/LF, LF/CR, LF or EOI; default CR/LF.
// - Cancel held five seconds shows versions, asks restore, default no.
// - Restore rewrites parameter words, never calibration words.
// - Defaults: 0 A, 0.01 A/s, 1 V, 60 A, 2 A/s, quench on, internal.
// - Power-up forces setpoint zero, heater off and local control.
// - Remote lights indicator, disables keypad; local key returns local.
package fpl_pkg;
	typedef enum logic [1:0] {SRC_INT, SRC_EXT, SRC_SUM} fpl_src_t;
	typedef enum logic [1:0] {LK_NONE, LK_ALL, LK_LIMITS} fpl_lock_t;
	typedef enum logic [1:0] {BD_9600, BD_19200, BD_38400, BD_57600} fpl_baud_t;
	typedef enum logic [1:0] {TM_CRLF, TM_LFCR, TM_LF, TM_EOI} fpl_term_t;
	typedef enum logic [2:0] {MSG_NONE, MSG_ACCEPTED, MSG_INVALID,
		MSG_LOCKED, MSG_VOLT_NZ, MSG_SET_NZ} fpl_msg_t;

	// Timing
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned HOLD_S        = 5;
	localparam int unsigned HOLD_CYCLES   = HOLD_S * CLK_HZ;
	// Scaling: setpoint in mA, external input in mV, 1 mV gives 10 mA
	localparam int          EXT_MA_PER_MV = 10;
	// Lock code, three BCD digits
	localparam logic [11:0] CODE_DEFAULT  = 12'h0123;
	// Bus address range and resets
	localparam logic [4:0]  ADDR_MIN      = 5'd1;
	localparam logic [4:0]  ADDR_MAX      = 5'd30;
	localparam logic [4:0]  ADDR_DEFAULT  = 5'd12;
	// Parameter word indices; calibration lives at CAL_BASE and above
	localparam logic [3:0]  IDX_RAMP      = 4'h0;
	localparam logic [3:0]  IDX_VLIM      = 4'h1;
	localparam logic [3:0]  IDX_IMAX      = 4'h2;
	localparam logic [3:0]  IDX_STEP      = 4'h3;
	localparam logic [3:0]  IDX_QUENCH    = 4'h4;
	localparam logic [3:0]  NUM_PARAMS    = 4'h5;
	localparam logic [3:0]  CAL_BASE      = 4'h8;
	// Defaults: ramp mA/s, limit mV, max mA, step mA/s, quench enable
	localparam logic [15:0] DEF_RAMP      = 16'h000A;
	localparam logic [15:0] DEF_VLIM      = 16'h03E8;
	localparam logic [15:0] DEF_IMAX      = 16'hEA60;
	localparam logic [15:0] DEF_STEP      = 16'h07D0;
	localparam logic [15:0] DEF_QUENCH    = 16'h0001;
	// Firmware version codes, values are arbitrary
	localparam logic [7:0]  MAIN_VERSION  = 8'h10;
	localparam logic [7:0]  CONV_VERSION  = 8'h10;
endpackage

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import fpl_pkg::*;
	localparam int unsigned HOLD = 8;
	// Key bits: 0 up,1 down,2 enter,3 esc,4 src,5 iface,6 local,7 digit,
	// 8 set,9 zero,10 heat on,11 heat off,12 param,13 remote,14 host code
	logic               clk = 1'b0;
	logic               reset_n = 1'b0;
	logic [14:0]        k = '0;
	logic [3:0]         dig = '0, pidx = '0, ridx = '0;
	logic signed [23:0] sval = '0;
	logic [15:0]        pval = '0;
	logic [11:0]        hcode = '0;
	logic               en_lvl = 1'b0, esc_lvl = 1'b0;
	logic               ce = 1'b1;
	logic signed [15:0] ext_tgt = '0;
	logic signed [15:0] ext_mv;
	logic signed [23:0] setpoint_ff, i_cmd_ff;
	fpl_src_t           src_ff;
	fpl_lock_t          lock_ff;
	fpl_baud_t          baud_ff;
	fpl_term_t          term_ff;
	fpl_msg_t           msg_ff;
	logic [4:0]         bus_addr_ff;
	logic [3:0]         screen_ff;
	logic [1:0]         sel_ff, stars_ff;
	logic [15:0]        version_ff, param_rd_data;
	logic               remote_led_ff, heater_on_ff, restore_busy_ff;
	logic [15:0]        defs [5] = '{DEF_RAMP, DEF_VLIM, DEF_IMAX,
		DEF_STEP, DEF_QUENCH};
	int                 fail_count = 0;
	int                 comparisons = 0;

	always #12.5 clk = ~clk;

	fpl_front_panel #(.HOLD(HOLD)) dut (.clk, .reset_n, .clk_en(ce),
		.key_up(k[0]), .key_down(k[1]), .key_enter(k[2]),
		.key_escape(k[3]), .key_ext_prog(k[4]), .key_comp_if(k[5]),
		.key_local(k[6]), .key_digit_vld(k[7]), .key_digit(dig),
		.enter_level(en_lvl), .escape_level(esc_lvl), .key_set_wr(k[8]),
		.key_set_val(sval), .key_zero(k[9]), .key_heater_on(k[10]),
		.key_heater_off(k[11]), .key_param_wr(k[12]), .key_param_idx(pidx),
		.key_param_val(pval), .param_rd_idx(ridx), .remote_req(k[13]),
		.host_code_wr(k[14]), .host_code(hcode), .ext_mv, .setpoint_ff,
		.i_cmd_ff, .src_ff, .lock_ff, .baud_ff, .bus_addr_ff, .term_ff,
		.msg_ff, .screen_ff, .sel_ff, .stars_ff, .version_ff,
		.remote_led_ff, .heater_on_ff, .restore_busy_ff, .param_rd_data);

	fpl_ext_src src_model (.clk, .reset_n, .target(ext_tgt), .ext_mv);

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Inputs move 2 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// One-cycle pulse, then an idle cycle so pulses never merge
	task automatic key(input int i);
		k = 15'h0001 << i;
		tick(1);
		k = '0;
		tick(1);
	endtask

	// First digit typed is the most significant; one star per digit
	task automatic code3(input logic [11:0] c);
		for (int i = 2; i >= 0; i--) begin
			dig = c[i*4 +: 4];
			key(7);
			if (i > 0)
				chk(stars_ff, 24'(3 - i));
		end
	endtask

	// Open a screen, move the selection up once, confirm
	task automatic up_ok(input int i);
		key(i);
		key(0);
		key(2);
	endtask

	// Open the lock screen, step the mode up once, type a code
	task automatic relock(input logic [11:0] c);
		hold(0);
		key(0);
		key(2);
		code3(c);
	endtask

	task automatic hold(input bit esc);
		en_lvl = !esc;
		esc_lvl = esc;
		tick(HOLD + 2);
		en_lvl = 1'b0;
		esc_lvl = 1'b0;
		tick(1);
	endtask

	task automatic close_out;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		tick(20000);
		fail_count++;
		close_out;
	end

	initial begin
		tick(8);
		reset_n = 1'b1;
		tick(1);
		chk(setpoint_ff, 24'h00_0000);
		chk(heater_on_ff, 1'b0);
		chk(remote_led_ff, 1'b0);
		chk(src_ff, SRC_INT);
		chk(baud_ff, BD_9600);
		chk(bus_addr_ff, ADDR_DEFAULT);
		chk(term_ff, TM_CRLF);
		// Source change refused on live voltage, then on live setpoint
		ext_tgt = 16'sh0064;
		tick(4);
		up_ok(4);
		chk(msg_ff, MSG_VOLT_NZ);
		ext_tgt = 16'sh0000;
		sval = 24'sh00_01F4;
		key(8);
		up_ok(4);
		chk(msg_ff, MSG_SET_NZ);
		chk(src_ff, SRC_INT);
		key(9);
		up_ok(4);
		chk(src_ff, SRC_EXT);
		// A panel write in external mode must not move the setpoint
		key(8);
		ext_tgt = 16'sh00FA;
		tick(8);
		chk(i_cmd_ff, 24'sh00_09C4);
		chk(setpoint_ff, 24'h00_0000);
		ext_tgt = 16'sh0000;
		tick(8);
		up_ok(4);
		chk(src_ff, SRC_SUM);
		sval = 24'sh01_1170;
		key(8);
		ext_tgt = 16'sh03E8;
		tick(30);
		// Sum above the 60 A maximum is passed unclamped
		chk(i_cmd_ff, 24'sh01_3880);
		ext_tgt = 16'sh0000;
		key(9);
		tick(30);
		up_ok(4);
		chk(src_ff, SRC_INT);
		// Interface screens; address clamps at the bottom
		up_ok(5);
		repeat (12) key(1);
		key(2);
		repeat (3) key(0);
		key(2);
		chk(baud_ff, BD_19200);
		chk(bus_addr_ff, ADDR_MIN);
		chk(term_ff, TM_EOI);
		key(5);
		key(0);
		key(3);
		chk(baud_ff, BD_19200);
		chk(screen_ff, 4'h0);
		// Remote ignores keys until local
		key(13);
		chk(remote_led_ff, 1'b1);
		key(4);
		chk(screen_ff, 4'h0);
		key(6);
		chk(remote_led_ff, 1'b0);
		// Clock enable low freezes all state, remote entry included
		ce = 1'b0;
		key(13);
		chk(remote_led_ff, 1'b0);
		ce = 1'b1;
		// Lock with a wrong then the right code
		hold(0);
		chk(screen_ff, 4'h5);
		key(0);
		key(2);
		code3(12'h0124);
		chk(msg_ff, MSG_INVALID);
		chk(lock_ff, LK_NONE);
		relock(CODE_DEFAULT);
		chk(lock_ff, LK_ALL);
		chk(msg_ff, MSG_ACCEPTED);
		pidx = IDX_RAMP;
		pval = 16'h0055;
		key(12);
		chk(msg_ff, MSG_LOCKED);
		// Full lock refuses the setpoint too
		key(3);
		key(8);
		chk(setpoint_ff, 24'h00_0000);
		chk(msg_ff, MSG_LOCKED);
		up_ok(4);
		chk(src_ff, SRC_INT);
		key(3);
		hold(1);
		key(0);
		key(2);
		chk(msg_ff, MSG_LOCKED);
		chk(restore_busy_ff, 1'b0);
		// New code from the computer side, then limits lock
		hcode = 12'h0456;
		key(14);
		relock(12'h0456);
		chk(lock_ff, LK_LIMITS);
		key(12);
		ridx = IDX_RAMP;
		tick(2);
		chk(param_rd_data, 16'h0055);
		pidx = IDX_IMAX;
		key(12);
		chk(msg_ff, MSG_LOCKED);
		key(10);
		chk(heater_on_ff, 1'b1);
		key(8);
		chk(setpoint_ff, sval);
		chk(i_cmd_ff, sval);
		relock(12'h0456);
		chk(lock_ff, LK_NONE);
		pidx = CAL_BASE;
		key(12);
		chk(msg_ff, MSG_LOCKED);
		// Restore defaults
		hold(1);
		chk(screen_ff, 4'h7);
		chk(sel_ff, 2'h0);
		chk(version_ff, {MAIN_VERSION, CONV_VERSION});
		key(0);
		key(2);
		chk(restore_busy_ff, 1'b1);
		for (int n = 0; n < 20 && restore_busy_ff !== 1'b0; n++)
			tick(1);
		chk(restore_busy_ff, 1'b0);
		for (int i = 0; i < 5; i++) begin
			ridx = i[3:0];
			tick(2);
			chk(param_rd_data, defs[i]);
		end
		chk(heater_on_ff, 1'b0);
		chk(setpoint_ff, 24'h00_0000);
		chk(baud_ff, BD_9600);
		chk(term_ff, TM_CRLF);
		chk(bus_addr_ff, ADDR_DEFAULT);
		relock(CODE_DEFAULT);
		chk(lock_ff, LK_ALL);
		close_out;
	end
endmodule
